//--- inc/dbg_phy_pkg.sv
// constants and types of the single-wire debug port register set
package dbg_phy_pkg;
	// ===================================================================
	// register offsets
	localparam logic [3:0] OFS_REV  = 4'h0;
	localparam logic [3:0] OFS_ERR  = 4'h1;
	localparam logic [3:0] OFS_CTLA = 4'h2;
	localparam logic [3:0] OFS_CTLB = 4'h3;
	localparam logic [3:0] OFS_KEY  = 4'h7;
	localparam logic [3:0] OFS_RST  = 4'h8;
	localparam logic [3:0] OFS_CLK  = 4'h9;
	// ===================================================================
	// field positions
	localparam int B_IBG    = 7;
	localparam int B_PARIGN = 5;
	localparam int B_TODIS  = 4;
	localparam int B_SIGOFF = 3;
	localparam int B_NACKD  = 4;
	localparam int B_CCDIS  = 3;
	localparam int B_PDIS   = 2;
	localparam int B_UROW   = 5;
	localparam int B_NVM    = 4;
	localparam int B_ERASE  = 3;
	localparam int REV_LSB  = 4;
	// ===================================================================
	// reset values and codes
	localparam logic [7:0] CTLA_RST   = 8'h00;
	localparam logic [2:0] CTLB_RST   = 3'h0;
	localparam logic [1:0] CLKDIV_RST = 2'h3;
	localparam logic [7:0] RST_SIG    = 8'h59;
	localparam logic [2:0] SIG_NONE    = 3'h0;
	localparam logic [2:0] SIG_PARITY  = 3'h1;
	localparam logic [2:0] SIG_FRAME   = 3'h2;
	localparam logic [2:0] SIG_TIMEOUT = 3'h3;
	localparam logic [2:0] SIG_START   = 3'h4;
	localparam logic [2:0] SIG_BUS     = 3'h6;
	localparam logic [2:0] SIG_CONTEND = 3'h7;
	localparam logic [2:0] GT_RSVD     = 3'h7;
	// ===================================================================
	// timing, in port clock cycles; inter-byte gap length in bit periods
	localparam logic [7:0] GUARD_MAX_CYC = 8'h80;
	localparam logic [1:0] IBG_BITS      = 2'h2;
	localparam int         TIMEOUT_CYC   = 65536;
	// ===================================================================
	// types
	typedef struct packed {
		logic       ibg;
		logic       par_ign;
		logic       to_dis;
		logic       sig_off;
		logic [2:0] gt;
	} link_cfg_t;
	typedef struct packed {
		logic par;
		logic frame;
		logic start;
		logic bus;
		logic contend;
	} link_err_t;
	typedef enum logic [1:0] {TA_IDLE, TA_GUARD, TA_DONE} turn_state_t;
endpackage

//--- core/debug_phy_regs.sv
// physical-layer and key register set of the single-wire debug port
`timescale 1ns/1ps
// How it works
// - link errors load 3-bit error signature; a debugger read clears it
// - parity error 0x1, stop-bit error 0x2, start-bit error 0x4
// - timeout 0x3, bus error 0x6, contention 0x7; 0x5 reserved
// - gap enable inserts two idle bits between multibyte load bytes
// - parity-ignore bit masks received parity errors; testing only
// - unless disabled, no access response in 65536 cycles flags timeout
// - response-signature-disable suppresses response signatures but not the nack
// - rx to tx guard time 128 cycles halved per code, 2 at 0x6
// - unless disabled, system reset during load/store sends a nack
// - contention detected when disable bit is zero, skipped when one
// - port-disable write drops clock request, resets config and keys
// - user-row key flag set on decode; debugger write ends session
// - nvm key flag set on decode, cleared when programming starts
// - erase key flag set on decode, cleared by erase reset request
// - writing 0x59 asserts system reset; other values release it
// - reset register reads bit 0 as reset held, others zero
// - system reset from the register never resets this port logic
// - clock divider 0..3 gives 32/16/8/4 MHz; 0x3 after reset, enable
// - revision status upper nibble is read-only port revision
// - registers reached only by debugger link instructions, never cpu
module debug_phy_regs
	import dbg_phy_pkg::*;
#(
	parameter int         TIMEOUT_LIMIT = TIMEOUT_CYC,
	parameter logic [3:0] PORT_REV      = 4'h5 // arbitrary value
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata_r,
	input  wire link_err_t   link_err,
	input  wire logic        acc_req,
	input  wire logic        acc_resp,
	input  wire logic        rx_to_tx,
	output logic             tx_go_r,
	input  wire logic        tx_byte_done,
	input  wire logic        multibyte_load,
	input  wire logic        bit_tick,
	output logic             tx_gap_r,
	input  wire logic        sig_req,
	output logic             sig_send_r,
	input  wire logic        sys_rst_seen,
	input  wire logic        op_busy,
	output logic             nack_send_r,
	input  wire logic        key_urow_ok,
	input  wire logic        key_nvm_ok,
	input  wire logic        key_erase_ok,
	input  wire logic        nvm_prog_started,
	input  wire logic        port_enable,
	output logic             clk_req_r,
	output logic             sys_reset_r,
	output logic      [1:0]  clk_div_r,
	output link_cfg_t        cfg_r,
	output logic             nack_dis_r,
	output logic             cont_det_dis_r,
	output logic      [2:0]  error_signature_r,
	output logic      [2:0]  key_flags_r
);
	default clocking dck @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// ===================================================================
	// register access decode; only the link instruction port reaches here
	logic wr_ctla, wr_ctlb, wr_key, wr_rst, wr_clk, rd_err;
	logic port_off; // port-disable write: acts as a soft reset
	assign wr_ctla  = reg_wr && reg_addr == OFS_CTLA;
	assign wr_ctlb  = reg_wr && reg_addr == OFS_CTLB;
	assign wr_key   = reg_wr && reg_addr == OFS_KEY;
	assign wr_rst   = reg_wr && reg_addr == OFS_RST;
	assign wr_clk   = reg_wr && reg_addr == OFS_CLK;
	assign rd_err   = reg_rd && reg_addr == OFS_ERR;
	assign port_off = wr_ctlb && reg_wdata[B_PDIS];

	// ===================================================================
	// control registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_r <= link_cfg_t'(CTLA_RST[6:0]);
		end else if (port_off) begin
			cfg_r <= link_cfg_t'(CTLA_RST[6:0]);
		end else if (wr_ctla) begin
			cfg_r <= {reg_wdata[B_IBG], reg_wdata[B_PARIGN:0]};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			{nack_dis_r, cont_det_dis_r, clk_req_r} <= {CTLB_RST[2:1], 1'b1};
		end else if (port_off) begin
			{nack_dis_r, cont_det_dis_r} <= CTLB_RST[2:1];
			clk_req_r                    <= 1'b0;
		end else begin
			if (wr_ctlb) begin
				nack_dis_r     <= reg_wdata[B_NACKD];
				cont_det_dis_r <= reg_wdata[B_CCDIS];
			end
			if (port_enable)
				clk_req_r <= 1'b1;
		end
	end

	// divider back to its default on reset and on re-enable
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clk_div_r <= CLKDIV_RST;
		end else if (port_off || port_enable) begin
			clk_div_r <= CLKDIV_RST;
		end else if (wr_clk) begin
			clk_div_r <= reg_wdata[1:0];
		end
	end

	// only rstn and port disable reset this logic; sys_reset_r resets the system, not this logic
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sys_reset_r <= 1'b0;
		end else if (port_off) begin
			sys_reset_r <= 1'b0;
		end else if (wr_rst) begin
			sys_reset_r <= reg_wdata == RST_SIG;
		end
	end
	a_reset_sig: assert property (
		wr_rst && !port_off
		|=> sys_reset_r == ($past(reg_wdata) == RST_SIG))
		else $error("reset request wrong");
	c_sys_reset: cover property ($rose(sys_reset_r) ##[1:50]
		$fell(sys_reset_r));

	// ===================================================================
	// key flags: set wins over clear, but port disable clears them even on a set
	logic erase_clr;
	assign erase_clr = wr_rst && reg_wdata == RST_SIG && !sys_reset_r;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			key_flags_r <= 3'h0;
		end else if (port_off) begin
			key_flags_r <= 3'h0;
		end else begin
			if (key_urow_ok)
				key_flags_r[2] <= 1'b1;
			else if (wr_key && reg_wdata[B_UROW])
				key_flags_r[2] <= 1'b0;
			if (key_nvm_ok)
				key_flags_r[1] <= 1'b1;
			else if (nvm_prog_started)
				key_flags_r[1] <= 1'b0;
			if (key_erase_ok)
				key_flags_r[0] <= 1'b1;
			else if (erase_clr)
				key_flags_r[0] <= 1'b0;
		end
	end
	a_port_off: assert property (
		port_off |=> !clk_req_r && key_flags_r == 3'h0
		&& clk_div_r == CLKDIV_RST)
		else $error("port disable incomplete");
	c_erase_clr: cover property (key_flags_r[0] && erase_clr);

	// ===================================================================
	// access-layer time-out
	logic [16:0] to_cnt_r;
	logic        to_run_r, to_hit;
	assign to_hit = to_run_r && !acc_resp &&
		to_cnt_r == 17'(TIMEOUT_LIMIT - 1);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			to_run_r <= 1'b0;
			to_cnt_r <= 17'h0;
		end else if (acc_req) begin
			to_run_r <= 1'b1;
			to_cnt_r <= 17'h0;
		end else if (acc_resp || to_hit || port_off) begin
			to_run_r <= 1'b0;
		end else if (to_run_r) begin
			to_cnt_r <= to_cnt_r + 17'h1;
		end
	end

	// ===================================================================
	// error signature; lowest line wins, a new error beats the read clear
	logic [2:0] err_code;
	always_comb begin
		err_code = SIG_NONE;
		if (link_err.contend && !cont_det_dis_r)
			err_code = SIG_CONTEND;
		else if (link_err.bus)
			err_code = SIG_BUS;
		else if (to_hit && !cfg_r.to_dis)
			err_code = SIG_TIMEOUT;
		else if (link_err.start)
			err_code = SIG_START;
		else if (link_err.frame)
			err_code = SIG_FRAME;
		else if (link_err.par && !cfg_r.par_ign)
			err_code = SIG_PARITY;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			error_signature_r <= SIG_NONE;
		end else if (err_code != SIG_NONE) begin
			error_signature_r <= err_code;
		end else if (rd_err || port_off) begin
			error_signature_r <= SIG_NONE;
		end
	end
	a_sig_clear: assert property (
		rd_err && err_code == SIG_NONE && !port_off
		|=> error_signature_r == SIG_NONE)
		else $error("error signature not cleared by read");
	a_parity_code: assert property (
		link_err == 5'b10000 && !cfg_r.par_ign
		|=> error_signature_r == SIG_PARITY)
		else $error("parity code wrong");
	a_parity_mask: assert property (
		cfg_r.par_ign && link_err == 5'b10000 && !to_hit
		|-> err_code == SIG_NONE)
		else $error("parity not ignored");
	a_contend_code: assert property (
		link_err.contend && !cont_det_dis_r
		|=> error_signature_r == SIG_CONTEND)
		else $error("contention code wrong");
	a_timeout_sig: assert property (
		to_hit && !cfg_r.to_dis && link_err == 5'b0
		|=> error_signature_r == SIG_TIMEOUT)
		else $error("timeout not flagged");
	c_timeout: cover property (to_hit && !cfg_r.to_dis);

	// ===================================================================
	// read data
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == OFS_REV)
				reg_rdata_r <= {PORT_REV, 4'h0};
			else if (reg_addr == OFS_ERR)
				reg_rdata_r <= {5'h0, error_signature_r};
			else if (reg_addr == OFS_CTLA)
				reg_rdata_r <= {cfg_r.ibg, 1'b0, cfg_r[5:0]};
			else if (reg_addr == OFS_CTLB)
				reg_rdata_r <= {3'h0, nack_dis_r, cont_det_dis_r, 3'h0};
			else if (reg_addr == OFS_KEY)
				reg_rdata_r <= {2'h0, key_flags_r, 3'h0};
			else if (reg_addr == OFS_RST)
				reg_rdata_r <= {7'h0, sys_reset_r};
			else if (reg_addr == OFS_CLK)
				reg_rdata_r <= {6'h0, clk_div_r};
			else
				reg_rdata_r <= 8'h00;
		end
	end
	a_rst_read: assert property (
		reg_rd && reg_addr == OFS_RST
		|=> reg_rdata_r == {7'h0, $past(sys_reset_r)})
		else $error("reset readback wrong");
	a_rev_read: assert property (
		reg_rd && reg_addr == OFS_REV
		|=> reg_rdata_r[7:4] == PORT_REV)
		else $error("revision wrong");

	// ===================================================================
	// rx to tx turnaround guard
	turn_state_t ta_r;
	logic [7:0]  gt_cnt_r, gt_len;
	assign gt_len = (cfg_r.gt == GT_RSVD) ? GUARD_MAX_CYC
		: GUARD_MAX_CYC >> cfg_r.gt;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ta_r     <= TA_IDLE;
			gt_cnt_r <= 8'h0;
			tx_go_r  <= 1'b0;
		end else begin
			tx_go_r <= 1'b0;
			case (ta_r)
				TA_IDLE: if (rx_to_tx) begin
					ta_r     <= TA_GUARD;
					gt_cnt_r <= gt_len - 8'h1;
				end
				TA_GUARD: if (gt_cnt_r == 8'h0) begin
					ta_r    <= TA_DONE;
					tx_go_r <= 1'b1;
				end else begin
					gt_cnt_r <= gt_cnt_r - 8'h1;
				end
				default: ta_r <= TA_IDLE;
			endcase
		end
	end
	a_guard_len: assert property (
		ta_r == TA_IDLE && rx_to_tx && cfg_r.gt == 3'h6
		|=> !tx_go_r [*2] ##1 tx_go_r)
		else $error("guard time wrong");

	// ===================================================================
	// inter-byte gap, counted in bit periods from the link's bit tick
	logic [1:0] gap_bits_r;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tx_gap_r   <= 1'b0;
			gap_bits_r <= 2'h0;
		end else if (tx_byte_done && multibyte_load && cfg_r.ibg) begin
			tx_gap_r   <= 1'b1;
			gap_bits_r <= IBG_BITS;
		end else if (tx_gap_r && bit_tick) begin
			gap_bits_r <= gap_bits_r - 2'h1;
			tx_gap_r   <= gap_bits_r != 2'h1;
		end
	end
	c_gap: cover property ($fell(tx_gap_r));

	// ===================================================================
	// response and nack signatures; signatures off needs predictable delay
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sig_send_r  <= 1'b0;
			nack_send_r <= 1'b0;
		end else begin
			sig_send_r  <= sig_req && !cfg_r.sig_off;
			nack_send_r <= sys_rst_seen && op_busy && !nack_dis_r;
		end
	end
	a_sig_quiet: assert property (
		$past(cfg_r.sig_off) |-> !sig_send_r)
		else $error("signature sent while disabled");
	a_nack_dis: assert property (
		sys_rst_seen && op_busy |=> nack_send_r == !$past(nack_dis_r))
		else $error("nack wrong");
endmodule // debug_phy_regs

//--- tb/link_far_model.sv
// far-side model: access-layer answers and link bit timing
`timescale 1ns/1ps
module link_far_model (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       acc_req,
	input  wire logic       resp_on,
	input  wire logic [7:0] resp_dly,
	output logic            acc_resp,
	output logic            bit_tick
);
	logic [7:0] wait_r;
	logic [1:0] phase_r;
	// ==================================================================
	// answer after a fixed delay, or never while resp_on is low
	// bit period of four clocks keeps the gap count easy to see
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wait_r   <= 8'h00;
			phase_r  <= 2'h0;
			acc_resp <= 1'h0;
			bit_tick <= 1'h0;
		end else begin
			phase_r  <= #1 phase_r + 2'h1;
			bit_tick <= #1 (phase_r == 2'h3);
			acc_resp <= #1 resp_on && (wait_r == 8'h01);
			if (acc_req)
				wait_r <= #1 resp_dly;
			else if (wait_r != 8'h00)
				wait_r <= #1 wait_r - 8'h01;
		end
	end
endmodule // link_far_model

//--- tb/single_wire_debug_phy_regs_test.sv
// self-checking bench of the debug port register set
`timescale 1ns/1ps
module single_wire_debug_phy_regs_test
	import dbg_phy_pkg::*;
;
	localparam int          TL     = 16;
	localparam logic [14:0] K_EN   = 15'h0001;
	localparam logic [14:0] K_NVS  = 15'h0002;
	localparam logic [14:0] K_KEYS = 15'h001c;
	localparam logic [14:0] K_SRS  = 15'h0020;
	localparam logic [14:0] K_SIG  = 15'h0040;
	localparam logic [14:0] K_TBD  = 15'h0080;
	localparam logic [14:0] K_RXT  = 15'h0100;
	localparam logic [14:0] K_ACC  = 15'h0200;
	localparam logic [14:0] K_ERR  = 15'h0400;
	logic        ref_clk, rstn, reg_wr, reg_rd, resp_on, op_busy;
	logic        acc_req, rx_to_tx, tx_byte_done, sig_req, sys_rst_seen;
	logic        key_urow_ok, key_nvm_ok, key_erase_ok, nvm_prog_started;
	logic        port_enable, multibyte_load, acc_resp, bit_tick, tx_go_r;
	logic        tx_gap_r, sig_send_r, nack_send_r, clk_req_r, sys_reset_r;
	logic        nack_dis_r, cont_det_dis_r;
	logic [1:0]  clk_div_r;
	logic [2:0]  error_signature_r, key_flags_r;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata_r, resp_dly, exp_gt;
	logic [14:0] pls;
	logic [2:0]  codes [5];
	link_err_t   link_err;
	link_cfg_t   cfg_r;
	int          fails, compares, n;
	// one vector carries every single-cycle pulse the bench raises except reg_wr and reg_rd
	assign {link_err, acc_req, rx_to_tx, tx_byte_done, sig_req, sys_rst_seen,
		key_urow_ok, key_nvm_ok, key_erase_ok, nvm_prog_started,
		port_enable} = pls;
	// port revision is an arbitrary value
	debug_phy_regs #(.TIMEOUT_LIMIT(TL), .PORT_REV(4'ha)) uut (
		.ref_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata_r, .link_err, .acc_req, .acc_resp, .rx_to_tx, .tx_go_r,
		.tx_byte_done, .multibyte_load, .bit_tick, .tx_gap_r, .sig_req,
		.sig_send_r, .sys_rst_seen, .op_busy, .nack_send_r, .key_urow_ok,
		.key_nvm_ok, .key_erase_ok, .nvm_prog_started, .port_enable,
		.clk_req_r, .sys_reset_r, .clk_div_r, .cfg_r, .nack_dis_r,
		.cont_det_dis_r, .error_signature_r, .key_flags_r);
	link_far_model far (.ref_clk, .rstn, .acc_req, .resp_on, .resp_dly,
		.acc_resp, .bit_tick);
	// ==================================================================
	// access tasks
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		tick;
		reg_wr = 1'h0;
		tick;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'h1;
		tick;
		reg_rd = 1'h0;
		tick;
		chk(reg_rdata_r, exp, "read");
	endtask
	task automatic pulse(input logic [14:0] v);
		pls = v;
		tick;
		pls = 15'h0000;
	endtask
	task automatic summarize;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==================================================================
	// clock and watchdog; the tests need about 650 cycles
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		summarize;
	end
	// ==================================================================
	// tests
	initial begin
		rstn = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		pls = 15'h0000;
		multibyte_load = 1'h0;
		op_busy = 1'h0;
		resp_on = 1'h1;
		resp_dly = 8'h04;
		codes = '{SIG_CONTEND, SIG_BUS, SIG_START, SIG_FRAME, SIG_PARITY};
		repeat (6) @(posedge ref_clk);
		#1;
		rstn = 1'h1;
		tick;
		rd(OFS_REV, 8'ha0);
		wr(OFS_REV, 8'hff);
		rd(OFS_REV, 8'ha0);
		rd(OFS_KEY, 8'h00);
		rd(4'h5, 8'h00);
		rd(OFS_CLK, 8'h03);
		wr(OFS_CTLA, 8'hff);
		rd(OFS_CTLA, 8'hbf);
		chk({1'h0, cfg_r}, 8'h7f, "cfg");
		wr(OFS_CTLB, 8'h18);
		rd(OFS_CTLB, 8'h18);
		chk({6'h00, nack_dis_r, cont_det_dis_r}, 8'h03, "ctlb out");
		for (int d = 0; d < 4; d++) begin
			wr(OFS_CLK, d[7:0]);
			rd(OFS_CLK, d[7:0]);
			chk({6'h00, clk_div_r}, d[7:0], "div out");
		end
		$display("register test done");
		wr(OFS_CTLB, 8'h00);
		wr(OFS_CTLA, 8'h00);
		for (int i = 0; i < 5; i++) begin
			pulse(K_ERR << i);
			tick;
			rd(OFS_ERR, {5'h00, codes[i]});
			rd(OFS_ERR, 8'h00);
		end
		pulse(15'h7c00);
		tick;
		chk({5'h00, error_signature_r}, {5'h00, SIG_CONTEND}, "sig out");
		rd(OFS_ERR, {5'h00, SIG_CONTEND});
		wr(OFS_CTLA, 8'h20);
		pulse(K_ERR << 4);
		tick;
		rd(OFS_ERR, 8'h00);
		wr(OFS_CTLB, 8'h08);
		pulse(15'h0c00);
		tick;
		rd(OFS_ERR, {5'h00, SIG_BUS});
		$display("error test done");
		for (int g = 0; g < 8; g++) begin
			wr(OFS_CTLA, {5'h00, g[2:0]});
			exp_gt = (g == 7) ? GUARD_MAX_CYC : GUARD_MAX_CYC >> g;
			pulse(K_RXT);
			n = 0;
			while (tx_go_r !== 1'h1 && n < 300) begin
				tick;
				n++;
			end
			chk(n[7:0], exp_gt, "guard");
		end
		wr(OFS_CTLA, 8'h80);
		multibyte_load = 1'h1;
		pulse(K_TBD);
		chk({7'h00, tx_gap_r}, 8'h01, "gap");
		n = 0;
		while (n < 2) begin
			@(posedge ref_clk);
			if (bit_tick)
				n++;
		end
		#1;
		chk({7'h00, tx_gap_r}, 8'h00, "gap end");
		multibyte_load = 1'h0;
		pulse(K_TBD);
		chk({7'h00, tx_gap_r}, 8'h00, "gap single");
		$display("timing test done");
		wr(OFS_CTLA, 8'h08);
		pulse(K_SIG);
		chk({7'h00, sig_send_r}, 8'h00, "sig off");
		wr(OFS_CTLA, 8'h00);
		pulse(K_SIG);
		chk({7'h00, sig_send_r}, 8'h01, "sig");
		tick;
		op_busy = 1'h1;
		pulse(K_SRS);
		chk({7'h00, nack_send_r}, 8'h01, "nack");
		wr(OFS_CTLB, 8'h10);
		pulse(K_SRS);
		chk({7'h00, nack_send_r}, 8'h00, "negative_ack_disable");
		op_busy = 1'h0;
		tick;
		$display("signature test done");
		pulse(K_KEYS);
		rd(OFS_KEY, 8'h38);
		chk({5'h00, key_flags_r}, 8'h07, "key out");
		wr(OFS_KEY, 8'h20);
		rd(OFS_KEY, 8'h18);
		pulse(K_NVS);
		rd(OFS_KEY, 8'h08);
		wr(OFS_CTLA, 8'h85);
		wr(OFS_RST, RST_SIG);
		rd(OFS_RST, 8'h01);
		chk({7'h00, sys_reset_r}, 8'h01, "sysrst");
		rd(OFS_KEY, 8'h00);
		rd(OFS_CTLA, 8'h85);
		wr(OFS_RST, 8'h58);
		rd(OFS_RST, 8'h00);
		$display("key test done");
		wr(OFS_CTLA, 8'h00);
		resp_on = 1'h0;
		pulse(K_ACC);
		repeat (TL - 6) tick;
		rd(OFS_ERR, 8'h00);
		repeat (8) tick;
		rd(OFS_ERR, {5'h00, SIG_TIMEOUT});
		resp_on = 1'h1;
		pulse(K_ACC);
		repeat (TL + 4) tick;
		rd(OFS_ERR, 8'h00);
		wr(OFS_CTLA, 8'h10);
		resp_on = 1'h0;
		pulse(K_ACC);
		repeat (TL + 4) tick;
		rd(OFS_ERR, 8'h00);
		wr(OFS_CLK, 8'h01);
		pulse(K_KEYS);
		wr(OFS_CTLB, 8'h1c);
		chk({7'h00, clk_req_r}, 8'h00, "clkreq off");
		rd(OFS_CTLA, 8'h00);
		rd(OFS_CTLB, 8'h00);
		rd(OFS_KEY, 8'h00);
		rd(OFS_CLK, 8'h03);
		pulse(K_EN);
		tick;
		chk({7'h00, clk_req_r}, 8'h01, "clkreq on");
		wr(OFS_CLK, 8'h01);
		pulse(K_EN);
		chk({6'h00, clk_div_r}, {6'h00, CLKDIV_RST}, "div on enable");
		$display("disable test done");
		summarize;
	end
endmodule // single_wire_debug_phy_regs_test
